// ### test/bsp_cmp_model.sv
`timescale 1ns/1ps

// ************************************************************
// Comparator and gate driver stand-in
// ************************************************************
module bsp_cmp_model (
    // Clock
    input wire logic aclk,
    // Gate commands
    input wire bsp_pkg::bsp_gate_s gate,
    // Bench controls
    input wire logic [7:0] peak_clks,
    input wire logic src_hi,
    input wire logic sink_hi,
    input wire bsp_pkg::bsp_cmp_s level,
    // Comparator levels
    output bsp_pkg::bsp_cmp_s cmp
);
    logic [7:0] on_clks = 8'h00;

    // Switch current ramps only while the high side conducts
    always @(posedge aclk) begin
        on_clks <= gate.hs ? on_clks + 8'h01 : 8'h00;
    end

    // Low-side limits sense only while the low side conducts,
    // so a limit can never be reported from an idle switch
    always_comb begin
        cmp = level;
        cmp.peak_trip = gate.hs && (on_clks >= peak_clks);
        cmp.ls_source_lim = src_hi && gate.ls;
        cmp.ls_sink_lim = sink_hi && gate.ls;
    end
endmodule : bsp_cmp_model

// ### test/buck_switch_protection_sequencer_tb.sv
`timescale 1ns/1ps
`include "bsp_defines.svh"

module buck_switch_protection_sequencer_tb;
    // ********************************************************
    // Signals
    // ********************************************************
    localparam int CYC = 30;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    // Enable above threshold, no faults
    bsp_pkg::bsp_cmp_s level = 9'h004;
    bsp_pkg::bsp_cmp_s cmp;
    bsp_pkg::bsp_gate_s gate;
    logic low_quiescent, soft_start_active;
    logic src_hi = 1'b0;
    logic sink_hi = 1'b0;
    logic [3:0] obs;
    logic ls_1, ls_2, hs_1, hs_2;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;

    assign obs = {gate.hs, gate.ls, soft_start_active, low_quiescent};

    always #50 aclk = ~aclk;

    // ********************************************************
    // Instances
    // ********************************************************
    bsp_sequencer #(.HICCUP_WAIT(4), .HICCUP_TIME(8), .THERMAL_TIME(8))
    dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .cmp(cmp), .gate(gate),
        .low_quiescent(low_quiescent),
        .soft_start_active(soft_start_active));

    bsp_cmp_model model_u (.aclk(aclk), .gate(gate),
        .peak_clks(8'h05), .src_hi(src_hi), .sink_hi(sink_hi),
        .level(level), .cmp(cmp));

    // ********************************************************
    // Tasks
    // ********************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen,
                want);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic write_chk(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] wr);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, wr});
    endtask : write_chk

    task automatic read_chk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] want, input logic [1:0] wr);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        check(rdata & m, want);
        check({30'h0, rresp}, {30'h0, wr});
    endtask : read_chk

    // Bounded wait; a miss shows up in the closing compare
    task automatic wait_obs(input logic [3:0] m, input logic [3:0] v,
        input int lim, output int cnt);
        cnt = 0;
        while ((obs & m) !== v && cnt < lim) begin
            @(posedge aclk);
            cnt++;
        end
        check({28'h0, obs & m}, {28'h0, v});
    endtask : wait_obs

    task automatic hold_obs(input logic [3:0] m, input logic [3:0] v,
        input int len);
        logic [3:0] bad;
        bad = 4'h0;
        repeat (len) begin
            @(posedge aclk);
            bad = bad | ((obs & m) ^ v);
        end
        check({28'h0, bad}, 32'h0);
    endtask : hold_obs

    // ********************************************************
    // Gate overlap monitor and timeout
    // ********************************************************
    always @(posedge aclk) begin
        ls_1 <= gate.ls;
        ls_2 <= ls_1;
        hs_1 <= gate.hs;
        hs_2 <= hs_1;
        cycles <= cycles + 1;
        if (aresetn) check({31'h0, (gate.hs & (gate.ls | ls_1 | ls_2)) |
            (gate.ls & (hs_1 | hs_2))}, 32'h0);
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    // ********************************************************
    // Scenarios
    // ********************************************************
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        wait_obs(4'b0011, 4'b0010, 4, n);
        read_chk(`BSP_ADDR_CTRL, 32'h1, `BSP_CTRL_RESET, `BSP_RESP_OKAY);
        read_chk(`BSP_ADDR_SSLEN, 32'hff, {24'h0, `BSP_SSLEN_RESET},
            `BSP_RESP_OKAY);
        read_chk(8'h14, 32'hffff_ffff, 32'h0, `BSP_RESP_SLVERR);
        write_chk(8'h14, 32'h1, `BSP_RESP_SLVERR);
        // Short soft start keeps the run brief
        write_chk(`BSP_ADDR_SSLEN, 32'h4, `BSP_RESP_OKAY);
        read_chk(`BSP_ADDR_SSLEN, 32'hff, 32'h4, `BSP_RESP_OKAY);
        wait_obs(4'b0010, 4'b0000, 40 * CYC, n);
        read_chk(`BSP_ADDR_STATUS, 32'h1f, 32'h4, `BSP_RESP_OKAY);
        wait_obs(4'b1000, 4'b1000, 2 * CYC, n);
        wait_obs(4'b1000, 4'b0000, 20, n);
        check(n, 6);
        wait_obs(4'b0100, 4'b0100, 8, n);
        check(n, 3);
        hold_obs(4'b1000, 4'b0000, 8);
        src_hi <= 1'b1;
        repeat (2 * CYC) @(posedge aclk);
        hold_obs(4'b1100, 4'b0100, 2 * CYC);
        src_hi <= 1'b0;
        wait_obs(4'b1000, 4'b1000, 3 * CYC, n);
        wait_obs(4'b0100, 4'b0100, CYC, n);
        sink_hi <= 1'b1;
        wait_obs(4'b0100, 4'b0000, 3, n);
        hold_obs(4'b1100, 4'b0000, 5);
        sink_hi <= 1'b0;
        level.overvoltage_guard <= 1'b1;
        repeat (2) @(posedge aclk);
        hold_obs(4'b1000, 4'b0000, 2 * CYC);
        level.overvoltage_guard <= 1'b0;
        wait_obs(4'b1000, 4'b1000, 2 * CYC + 2, n);
        level.boot_uv <= 1'b1;
        wait_obs(4'b1100, 4'b0100, 6, n);
        level.boot_uv <= 1'b0;
        level.overload <= 1'b1;
        repeat (3 * CYC) @(posedge aclk);
        level.overload <= 1'b0;
        repeat (CYC) @(posedge aclk);
        level.overload <= 1'b1;
        repeat (3 * CYC) @(posedge aclk);
        read_chk(`BSP_ADDR_STATUS, 32'h1f, 32'h4, `BSP_RESP_OKAY);
        repeat (4 * CYC) @(posedge aclk);
        read_chk(`BSP_ADDR_STATUS, 32'h1f, 32'h8, `BSP_RESP_OKAY);
        read_chk(`BSP_ADDR_FAULT, 32'h8, 32'h8, `BSP_RESP_OKAY);
        level.overload <= 1'b0;
        hold_obs(4'b1110, 4'b0000, 2 * CYC);
        wait_obs(4'b0010, 4'b0010, 8 * CYC, n);
        wait_obs(4'b0010, 4'b0000, 6 * CYC, n);
        level.over_temp <= 1'b1;
        repeat (4) @(posedge aclk);
        hold_obs(4'b1110, 4'b0000, 3 * CYC);
        read_chk(`BSP_ADDR_STATUS, 32'h1f, 32'h10, `BSP_RESP_OKAY);
        level.over_temp <= 1'b0;
        hold_obs(4'b1110, 4'b0000, 6 * CYC);
        wait_obs(4'b0010, 4'b0010, 4 * CYC, n);
        level.vin_uv <= 1'b1;
        wait_obs(4'b0001, 4'b0001, 4, n);
        hold_obs(4'b1100, 4'b0000, CYC);
        level.vin_uv <= 1'b0;
        wait_obs(4'b0011, 4'b0010, 4, n);
        level.en_above <= 1'b0;
        wait_obs(4'b0001, 4'b0001, 4, n);
        hold_obs(4'b1110, 4'b0000, 2 * CYC);
        level.en_above <= 1'b1;
        wait_obs(4'b0011, 4'b0010, 4, n);
        write_chk(`BSP_ADDR_CTRL, 32'h0, `BSP_RESP_OKAY);
        wait_obs(4'b1111, 4'b0001, 4, n);
        close_out();
    end
endmodule : buck_switch_protection_sequencer_tb

// ### verilog/bsp_defines.svh
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH

// ****************************************************************
// Clock and switching timing
// ****************************************************************
`define BSP_CLK_NS 100
`define BSP_SW_PERIOD_NS 3000
`define BSP_DEAD_NS 200
`define BSP_SW_CLKS (`BSP_SW_PERIOD_NS / `BSP_CLK_NS)
`define BSP_DEAD_CLKS ((`BSP_DEAD_NS + `BSP_CLK_NS - 1) / `BSP_CLK_NS)
`define BSP_PH_W 5

// ****************************************************************
// Hiccup counts in switching cycles
// ****************************************************************
`define BSP_HICCUP_WAIT 512
`define BSP_HICCUP_TIME 16384
`define BSP_THERMAL_TIME 32768

// ****************************************************************
// Register offsets, fields and reset values
// ****************************************************************
`define BSP_ADDR_CTRL 8'h00
`define BSP_ADDR_SSLEN 8'h04
`define BSP_ADDR_STATUS 8'h08
`define BSP_ADDR_FAULT 8'h0c
`define BSP_ADDR_HICCUP 8'h10
`define BSP_CTRL_RUN 0
`define BSP_CTRL_RESET 32'h0000_0001
`define BSP_SSLEN_RESET 8'h20
`define BSP_FLT_PEAK 0
`define BSP_FLT_SOURCE 1
`define BSP_FLT_SINK 2
`define BSP_FLT_OVLD 3
`define BSP_FLT_THERM 4
`define BSP_FLT_UV 5
`define BSP_FLT_W 6
`define BSP_RESP_OKAY 2'b00
`define BSP_RESP_SLVERR 2'b10

`endif

// ### verilog/bsp_pkg.sv
package bsp_pkg;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [4:0] {
        ST_OFF  = 5'b00001,
        ST_SOFT = 5'b00010,
        ST_RUN  = 5'b00100,
        ST_OVLD = 5'b01000,
        ST_TSD  = 5'b10000
    } bsp_state_e;

    // ************************************************************
    // Comparator indications and gate commands
    // ************************************************************
    typedef struct packed {
        logic peak_trip;
        logic ls_source_lim;
        logic ls_sink_lim;
        logic overload;
        logic over_temp;
        logic vin_uv;
        logic en_above;
        logic overvoltage_guard;
        logic boot_uv;
    } bsp_cmp_s;

    typedef struct packed {
        logic hs;
        logic ls;
    } bsp_gate_s;

endpackage : bsp_pkg

// ### verilog/bsp_sequencer.sv
`timescale 1ns/1ps
`include "bsp_defines.svh"

module bsp_sequencer #(
    parameter int HICCUP_WAIT = `BSP_HICCUP_WAIT,
    parameter int HICCUP_TIME = `BSP_HICCUP_TIME,
    parameter int THERMAL_TIME = `BSP_THERMAL_TIME
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Comparators
    input wire bsp_pkg::bsp_cmp_s cmp,
    // Gate drive and mode
    output bsp_pkg::bsp_gate_s gate,
    output logic low_quiescent,
    output logic soft_start_active
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam logic [`BSP_PH_W-1:0] PH_LAST = `BSP_PH_W'(`BSP_SW_CLKS - 1);
    localparam logic [`BSP_PH_W-1:0] PH_DEAD = `BSP_PH_W'(`BSP_DEAD_CLKS);
    localparam logic [10:0] OVL_WAIT = 11'(HICCUP_WAIT);
    localparam logic [15:0] OVL_TIME = 16'(HICCUP_TIME - 1);
    localparam logic [15:0] TSD_TIME = 16'(THERMAL_TIME - 1);

    bsp_pkg::bsp_state_e state;
    bsp_pkg::bsp_state_e next_state;
    logic [`BSP_PH_W-1:0] ph;
    logic [`BSP_PH_W-1:0] dt;
    logic [10:0] ovl_cnt;
    logic [15:0] hic_cnt;
    logic [7:0] ss_cnt;
    logic [7:0] ss_len;
    logic run_en;
    logic hs_stop;
    logic sink_off;
    logic skip;
    logic ovp_hold;
    logic [`BSP_FLT_W-1:0] fault;
    logic [7:0] aw_addr;
    logic aw_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_got;

    // ************************************************************
    // Cycle phase and conditions
    // ************************************************************
    function automatic logic [31:0] wmask(input logic [3:0] s);
        wmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : wmask

    wire cyc_end = (ph == PH_LAST);
    wire active = (state == bsp_pkg::ST_SOFT) || (state == bsp_pkg::ST_RUN);
    wire off_cond = cmp.vin_uv || !cmp.en_above || !run_en;
    wire ss_ok = (state == bsp_pkg::ST_RUN) ||
        ({3'b000, ph - PH_DEAD} < ss_cnt);
    // High side only after the cycle's leading gap, blocked by any trip
    wire hs_want = active && (ph >= PH_DEAD) && !hs_stop &&
        !cmp.peak_trip && !skip && !cmp.overvoltage_guard &&
        !ovp_hold && !cmp.boot_uv && !sink_off && ss_ok;
    wire ls_want = active && !hs_want && (hs_stop || skip || cmp.boot_uv)
        && !sink_off && !cmp.ls_sink_lim;
    wire next_hs = hs_want && !gate.ls && (dt == '0);
    wire next_ls = ls_want && !gate.hs && (dt == '0);
    wire gate_fall = (gate.hs && !next_hs) || (gate.ls && !next_ls);

    // ************************************************************
    // Oscillator phase and gate drive
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph <= '0;
        end else begin
            ph <= cyc_end ? '0 : ph + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate <= '0;
            dt <= '0;
        end else begin
            gate.hs <= next_hs;
            gate.ls <= next_ls;
            // A falling gate reloads the gap, so no edge can overlap
            if (gate_fall) begin
                dt <= PH_DEAD;
            end else if (dt != '0) begin
                dt <= dt - 1'b1;
            end
        end
    end

    // ************************************************************
    // Per-cycle protection latches
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_stop <= 1'b0;
            sink_off <= 1'b0;
            skip <= 1'b0;
            ovp_hold <= 1'b0;
        end else if (cyc_end) begin
            hs_stop <= 1'b0;
            sink_off <= 1'b0;
            skip <= gate.ls && cmp.ls_source_lim;
            ovp_hold <= cmp.overvoltage_guard;
        end else begin
            if (cmp.peak_trip || (gate.hs && !hs_want)) begin
                hs_stop <= 1'b1;
            end
            if (active && cmp.ls_sink_lim) begin
                sink_off <= 1'b1;
            end
            if (cmp.overvoltage_guard) begin
                ovp_hold <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Operating state
    // ************************************************************
    always_comb begin
        next_state = state;
        if (off_cond) begin
            next_state = bsp_pkg::ST_OFF;
        end else if (cmp.over_temp) begin
            next_state = bsp_pkg::ST_TSD;
        end else begin
            case (state)
                bsp_pkg::ST_OFF: next_state = bsp_pkg::ST_SOFT;
                bsp_pkg::ST_SOFT: begin
                    if (ovl_cnt > OVL_WAIT) begin
                        next_state = bsp_pkg::ST_OVLD;
                    end else if (cyc_end && ss_cnt >= ss_len) begin
                        next_state = bsp_pkg::ST_RUN;
                    end
                end
                bsp_pkg::ST_RUN: begin
                    if (ovl_cnt > OVL_WAIT) begin
                        next_state = bsp_pkg::ST_OVLD;
                    end
                end
                bsp_pkg::ST_OVLD: begin
                    if (cyc_end && hic_cnt == OVL_TIME) begin
                        next_state = bsp_pkg::ST_SOFT;
                    end
                end
                bsp_pkg::ST_TSD: begin
                    if (cyc_end && hic_cnt == TSD_TIME) begin
                        next_state = bsp_pkg::ST_OFF;
                    end
                end
                default: next_state = bsp_pkg::ST_OFF;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= bsp_pkg::ST_OFF;
            low_quiescent <= 1'b1;
            soft_start_active <= 1'b0;
        end else begin
            state <= next_state;
            low_quiescent <= (next_state == bsp_pkg::ST_OFF);
            soft_start_active <= (next_state == bsp_pkg::ST_SOFT);
        end
    end

    // ************************************************************
    // Hiccup and soft-start counters
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn || next_state != state) begin
            hic_cnt <= '0;
        end else if (cmp.over_temp) begin
            hic_cnt <= '0;
        end else if (cyc_end && (state == bsp_pkg::ST_OVLD ||
                state == bsp_pkg::ST_TSD)) begin
            hic_cnt <= hic_cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !active) begin
            ovl_cnt <= '0;
        end else if (cyc_end) begin
            // Only consecutive overloaded cycles count
            if (!cmp.overload) begin
                ovl_cnt <= '0;
            end else if (ovl_cnt != '1) begin
                ovl_cnt <= ovl_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state != bsp_pkg::ST_SOFT) begin
            ss_cnt <= '0;
        end else if (cyc_end && ss_cnt != '1) begin
            ss_cnt <= ss_cnt + 1'b1;
        end
    end

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    wire do_write = aw_got && w_got && !bvalid;
    wire [31:0] wm = wmask(w_strb);
    wire wr_ctrl = do_write && aw_addr == `BSP_ADDR_CTRL;
    wire wr_ss = do_write && aw_addr == `BSP_ADDR_SSLEN;
    wire wr_flt = do_write && aw_addr == `BSP_ADDR_FAULT;
    wire wr_hit = wr_ctrl || wr_ss || wr_flt ||
        aw_addr == `BSP_ADDR_STATUS || aw_addr == `BSP_ADDR_HICCUP;
    wire [`BSP_FLT_W-1:0] flt_clr = wr_flt ?
        (w_data[`BSP_FLT_W-1:0] & wm[`BSP_FLT_W-1:0]) : '0;
    wire [`BSP_FLT_W-1:0] flt_set = {cmp.vin_uv,
        next_state == bsp_pkg::ST_TSD && state != bsp_pkg::ST_TSD,
        next_state == bsp_pkg::ST_OVLD && state != bsp_pkg::ST_OVLD,
        active && cmp.ls_sink_lim,
        cyc_end && gate.ls && cmp.ls_source_lim,
        gate.hs && cmp.peak_trip};
    wire [31:0] status_word = {5'h00, ovl_cnt, 4'h0, skip, sink_off,
        gate.hs, gate.ls, 3'h0, state};
    wire [31:0] rd_word =
        (araddr == `BSP_ADDR_CTRL) ? {31'h0, run_en} :
        (araddr == `BSP_ADDR_SSLEN) ? {24'h0, ss_len} :
        (araddr == `BSP_ADDR_STATUS) ? status_word :
        (araddr == `BSP_ADDR_FAULT) ? {26'h0, fault} :
        (araddr == `BSP_ADDR_HICCUP) ? {16'h0, hic_cnt} : 32'h0;
    wire rd_hit = araddr == `BSP_ADDR_CTRL || araddr == `BSP_ADDR_SSLEN ||
        araddr == `BSP_ADDR_STATUS || araddr == `BSP_ADDR_FAULT ||
        araddr == `BSP_ADDR_HICCUP;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= `BSP_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_addr <= awaddr;
                aw_got <= 1'b1;
                awready <= 1'b0;
            end else if (!aw_got && !bvalid) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                w_data <= wdata;
                w_strb <= wstrb;
                w_got <= 1'b1;
                wready <= 1'b0;
            end else if (!w_got && !bvalid) begin
                wready <= 1'b1;
            end
            if (do_write) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? `BSP_RESP_OKAY : `BSP_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `BSP_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? `BSP_RESP_OKAY : `BSP_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // Set wins over a same-cycle software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_en <= 1'(`BSP_CTRL_RESET);
            ss_len <= `BSP_SSLEN_RESET;
            fault <= '0;
        end else begin
            if (wr_ctrl && w_strb[0]) begin
                run_en <= w_data[`BSP_CTRL_RUN];
            end
            if (wr_ss && w_strb[0]) begin
                ss_len <= w_data[7:0];
            end
            fault <= (fault & ~flt_clr) | flt_set;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_excl;
        !(gate.hs && gate.ls);
    endproperty
    a_excl: assert property (p_excl) else $error("gates overlap");

    property p_gap;
        $fell(gate.hs) |-> !gate.ls [*3];
    endproperty
    a_gap: assert property (p_gap) else $error("no dead time");

    property p_peak;
        (cmp.peak_trip && !cyc_end) |=> !gate.hs until (ph == '0);
    endproperty
    a_peak: assert property (p_peak) else $error("peak not obeyed");

    property p_sink;
        (cmp.ls_sink_lim && !cyc_end) |=> !gate.ls && !gate.hs;
    endproperty
    a_sink: assert property (p_sink) else $error("sink not obeyed");

    property p_skip;
        (cyc_end && gate.ls && cmp.ls_source_lim) |=> skip && !gate.hs;
    endproperty
    a_skip: assert property (p_skip) else $error("no skip");

    property p_ovp;
        cmp.overvoltage_guard |=> !gate.hs;
    endproperty
    a_ovp: assert property (p_ovp) else $error("ovp ignored");

    property p_boot;
        cmp.boot_uv |=> !gate.hs;
    endproperty
    a_boot: assert property (p_boot) else $error("boot ignored");

    property p_off;
        off_cond |=> low_quiescent ##1 (!gate.hs && !gate.ls);
    endproperty
    a_off: assert property (p_off) else $error("no shutdown");

    property p_tsd;
        (cmp.over_temp && !off_cond) |=> state == bsp_pkg::ST_TSD;
    endproperty
    a_tsd: assert property (p_tsd) else $error("no thermal stop");

    property p_ovl;
        (active && ovl_cnt > OVL_WAIT && !off_cond && !cmp.over_temp)
            |=> state == bsp_pkg::ST_OVLD ##1 !gate.hs;
    endproperty
    a_ovl: assert property (p_ovl) else $error("no hiccup");

endmodule : bsp_sequencer
